// File: core/priority_interrupt_standby_wake.sv
`timescale 1ns/10ps
// How it works
// - three levels X>H>L; refuse requests at or below the serviced level.
// - among pending vectors the highest assigned level is granted.
// - on equal level the smallest vector address is granted.
// - nineteen sources share ten vectors from 03h to 4Bh, step eight.
// - vectors of lines A and B take X or L; the rest H or L.
// - 13h serves lines C, E and timer-0 low; 1Bh line D, base timer.
// - 43h converter, timers 6 and 7, pulse channels; 4Bh port 0.
// - halt stops the CPU only; peripherals and oscillators keep running.
// - halt ends on reset pin, low voltage, watchdog or any interrupt.
// - hold stops CPU, peripherals and every oscillator.
// - hold ends on resets, lines A, B, C, E or port 0.
// - lines A and B wake from hold only in level-detect mode.
// - crystal hold keeps base timer and the crystal state of entry.
// - base timer wakes crystal hold only with crystal selected.
module priority_interrupt_standby_wake (
	input wire logic clk,
	input wire logic rst,
	input wire logic [pic_pkg::ADDR_WIDTH-1:0] addr,
	input wire logic [pic_pkg::DATA_WIDTH-1:0] wdata,
	input wire logic write_strobe,
	input wire logic read_strobe,
	output logic [pic_pkg::DATA_WIDTH-1:0] rdata,
	input wire logic [pic_pkg::NUM_SOURCES-1:0] src_event,
	input wire logic cpu_ack,
	input wire logic cpu_return,
	output logic irq_request,
	output logic [7:0] vector_addr,
	output logic [1:0] irq_level,
	output logic int_out,
	input wire logic reset_pin_n,
	input wire logic low_voltage_detect_reset,
	input wire logic watchdog_reset,
	output logic [3:0] standby_mode,
	output logic cpu_stop,
	output logic periph_stop,
	output logic base_timer_stop,
	output logic osc_stop,
	output logic crystal_stop
);
	import pic_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [NUM_SOURCES-1:0] status;
		logic [NUM_SOURCES-1:0] mask;
		logic [NUM_VECTORS-1:0] prio;
		logic [3:0] control;
		logic [2:0] in_service;
		logic irq_request;
		logic [7:0] vector_addr;
		logic [1:0] irq_level;
		logic int_out;
		logic [DATA_WIDTH-1:0] rdata;
		logic enter_req;
		logic [1:0] enter_mode;
	} state_type;

	state_type cur;
	state_type next_cur;
	logic [NUM_VECTORS-1:0] pend_vec;
	logic [2*NUM_VECTORS-1:0] vec_level;
	logic win_valid;
	logic [3:0] win_vector;
	logic [1:0] win_level;
	logic [1:0] cur_level;
	logic [NUM_SOURCES-1:0] next_status;
	logic hold_wake;

	// ----------------------------------------------------------------
	// level and vector decode
	// ----------------------------------------------------------------
	always_comb begin
		pend_vec = '0;
		for (int i = 0; i < NUM_SOURCES; i++)
			pend_vec[src_vector(i)] = pend_vec[src_vector(i)] |
				(cur.status[i] & cur.mask[i]);
	end

	// one bit per vector can only select a permitted level
	generate
		for (genvar v = 0; v < NUM_VECTORS; v++) begin: g_level
			if (v < 2) begin: g_ext
				assign vec_level[2*v +: 2] = cur.prio[v] ?
					LEVEL_HIGHEST : LEVEL_LOW;
			end else begin: g_other
				assign vec_level[2*v +: 2] = cur.prio[v] ?
					LEVEL_HIGH : LEVEL_LOW;
			end
		end
	endgenerate

	vector_arbiter u_arbiter (
		.pending(pend_vec),
		.level(vec_level),
		.win_valid(win_valid),
		.win_vector(win_vector),
		.win_level(win_level)
	);

	always_comb begin
		if (cur.in_service[2])
			cur_level = LEVEL_HIGHEST;
		else if (cur.in_service[1])
			cur_level = LEVEL_HIGH;
		else if (cur.in_service[0])
			cur_level = LEVEL_LOW;
		else
			cur_level = LEVEL_NONE;
	end

	// edge-detected A and B events cannot wake from hold
	assign hold_wake = (src_event[SRC_EXT_LINE_A] &&
		cur.control[CTRL_LEVEL_A]) ||
		(src_event[SRC_EXT_LINE_B] && cur.control[CTRL_LEVEL_B]) ||
		src_event[SRC_EXT_LINE_C] || src_event[SRC_EXT_LINE_E] ||
		src_event[SRC_PORT_ZERO];

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_cur = cur;
		next_cur.rdata = '0;
		next_cur.enter_req = 1'b0;
		next_status = cur.status;
		if (write_strobe && addr == OFFSET_STATUS)
			next_status = next_status & ~wdata[NUM_SOURCES-1:0];
		// a new event wins over a write-one clear in the same cycle
		next_status = next_status | src_event;
		next_cur.status = next_status;
		if (write_strobe) begin
			case (addr)
				OFFSET_MASK: next_cur.mask = wdata[NUM_SOURCES-1:0];
				OFFSET_PRIORITY: next_cur.prio = wdata[NUM_VECTORS-1:0];
				OFFSET_CONTROL: begin
					next_cur.control = wdata[3:0];
					next_cur.enter_mode = wdata[CTRL_MODE_LSB +: 2];
					next_cur.enter_req = wdata[CTRL_MODE_LSB +: 2] != REQ_NONE;
				end
				default: ;
			endcase
		end
		if (read_strobe) begin
			case (addr)
				OFFSET_STATUS: next_cur.rdata = {13'h0000, cur.status};
				OFFSET_MASK: next_cur.rdata = {13'h0000, cur.mask};
				OFFSET_PRIORITY: next_cur.rdata = {22'h00_0000, cur.prio};
				OFFSET_CONTROL: next_cur.rdata = {28'h000_0000, cur.control};
				OFFSET_STATE: next_cur.rdata = {12'h000, cur.vector_addr,
					cur.irq_request, cur.irq_level, cur.in_service,
					standby_mode, cur.int_out, 1'b0};
				default: next_cur.rdata = '0;
			endcase
		end
		// nesting: the CPU takes a vector, then returns from it
		if (cpu_return) begin
			if (cur.in_service[2])
				next_cur.in_service[2] = 1'b0;
			else if (cur.in_service[1])
				next_cur.in_service[1] = 1'b0;
			else
				next_cur.in_service[0] = 1'b0;
		end
		if (cpu_ack && cur.irq_request) begin
			case (cur.irq_level)
				LEVEL_HIGHEST: next_cur.in_service[2] = 1'b1;
				LEVEL_HIGH: next_cur.in_service[1] = 1'b1;
				default: next_cur.in_service[0] = 1'b1;
			endcase
		end
		next_cur.irq_request = win_valid && win_level > cur_level &&
			!(cpu_ack && cur.irq_request);
		next_cur.irq_level = win_level;
		next_cur.vector_addr = VECTOR_BASE +
			8'({win_vector, 3'b000});
		next_cur.int_out = |(next_status & cur.mask);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cur <= '{RESET_STATUS, RESET_MASK, RESET_PRIORITY, RESET_CONTROL,
				3'h0, 1'b0, VECTOR_BASE, LEVEL_NONE, 1'b0, 32'h0000_0000,
				1'b0, REQ_NONE};
		end else begin
			cur <= next_cur;
		end
	end

	// ----------------------------------------------------------------
	// standby
	// ----------------------------------------------------------------
	standby_control u_standby (
		.clk(clk),
		.rst(rst),
		.enter_req(cur.enter_req),
		.enter_mode(cur.enter_mode),
		.reset_pin_n(reset_pin_n),
		.low_voltage_detect_reset(low_voltage_detect_reset),
		.watchdog_reset(watchdog_reset),
		.any_interrupt(cur.int_out),
		.hold_wake(hold_wake),
		.base_timer_event(src_event[SRC_BASE_TIMER]),
		.crystal_sel(cur.control[CTRL_CRYSTAL_SEL]),
		.crystal_on(cur.control[CTRL_CRYSTAL_ON]),
		.mode(standby_mode),
		.cpu_stop(cpu_stop),
		.periph_stop(periph_stop),
		.base_timer_stop(base_timer_stop),
		.osc_stop(osc_stop),
		.crystal_stop(crystal_stop)
	);

	assign rdata = cur.rdata;
	assign irq_request = cur.irq_request;
	assign vector_addr = cur.vector_addr;
	assign irq_level = cur.irq_level;
	assign int_out = cur.int_out;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic higher_pending;
	logic lower_tie;
	always_comb begin
		higher_pending = 1'b0;
		lower_tie = 1'b0;
		for (int i = 0; i < NUM_VECTORS; i++) begin
			if (pend_vec[i] && vec_level[2*i +: 2] > win_level)
				higher_pending = 1'b1;
			if (pend_vec[i] && i < int'(win_vector) &&
				vec_level[2*i +: 2] == win_level)
				lower_tie = 1'b1;
		end
	end

	property p_refuse_not_above;
		@(posedge clk) disable iff (rst)
		irq_request && !$past(cpu_return) |-> irq_level > cur_level;
	endproperty
	a_refuse_not_above: assert property (p_refuse_not_above)
		else $error("request not above serviced level");

	sequence s_taken;
		irq_request && cpu_ack;
	endsequence
	sequence s_serviced;
		cur_level == $past(irq_level);
	endsequence
	property p_ack_raises_level;
		@(posedge clk) disable iff (rst)
		s_taken and !cpu_return |=> s_serviced;
	endproperty
	a_ack_raises_level: assert property (p_ack_raises_level)
		else $error("acknowledge did not raise serviced level");

	property p_highest_wins;
		@(posedge clk) disable iff (rst)
		win_valid |-> !higher_pending;
	endproperty
	a_highest_wins: assert property (p_highest_wins)
		else $error("lower level granted over higher");

	property p_smallest_wins;
		@(posedge clk) disable iff (rst)
		win_valid |-> !lower_tie;
	endproperty
	a_smallest_wins: assert property (p_smallest_wins)
		else $error("larger vector granted on a tie");

	property p_vector_range;
		@(posedge clk) disable iff (rst)
		irq_request |-> vector_addr >= 8'h03 && vector_addr <= 8'h4b &&
			vector_addr[2:0] == 3'h3;
	endproperty
	a_vector_range: assert property (p_vector_range)
		else $error("vector address outside the table");

	property p_level_permitted;
		@(posedge clk) disable iff (rst)
		irq_request && vector_addr > 8'h0b |-> irq_level != LEVEL_HIGHEST;
	endproperty
	a_level_permitted: assert property (p_level_permitted)
		else $error("highest level on a later vector");

	property p_port_zero_vector;
		@(posedge clk) disable iff (rst)
		(cur.status & cur.mask) == 19'h4_0000 |=> vector_addr == 8'h4b;
	endproperty
	a_port_zero_vector: assert property (p_port_zero_vector)
		else $error("port zero not on its vector");

	property p_edge_no_wake;
		@(posedge clk) disable iff (rst)
		src_event == 19'h0_0001 && !cur.control[CTRL_LEVEL_A] |-> !hold_wake;
	endproperty
	a_edge_no_wake: assert property (p_edge_no_wake)
		else $error("edge mode line A woke hold");
endmodule: priority_interrupt_standby_wake

// File: core/pic_pkg.sv
package pic_pkg;
	// ----------------------------------------------------------------
	// sizes and register map
	// ----------------------------------------------------------------
	localparam int unsigned NUM_SOURCES = 19;
	localparam int unsigned NUM_VECTORS = 10;
	localparam int unsigned ADDR_WIDTH = 8;
	localparam int unsigned DATA_WIDTH = 32;

	localparam logic [7:0] OFFSET_STATUS = 8'h00;
	localparam logic [7:0] OFFSET_MASK = 8'h04;
	localparam logic [7:0] OFFSET_PRIORITY = 8'h08;
	localparam logic [7:0] OFFSET_CONTROL = 8'h0c;
	localparam logic [7:0] OFFSET_STATE = 8'h10;

	localparam logic [18:0] RESET_STATUS = 19'h0_0000;
	localparam logic [18:0] RESET_MASK = 19'h0_0000;
	localparam logic [9:0] RESET_PRIORITY = 10'h000;
	localparam logic [3:0] RESET_CONTROL = 4'h0;

	// control register fields
	localparam int unsigned CTRL_LEVEL_A = 0;
	localparam int unsigned CTRL_LEVEL_B = 1;
	localparam int unsigned CTRL_CRYSTAL_SEL = 2;
	localparam int unsigned CTRL_CRYSTAL_ON = 3;
	localparam int unsigned CTRL_MODE_LSB = 4;

	// ----------------------------------------------------------------
	// vectors and sources
	// ----------------------------------------------------------------
	localparam logic [7:0] VECTOR_BASE = 8'h03;
	localparam int unsigned VECTOR_STEP_SHIFT = 3;

	localparam int unsigned SRC_EXT_LINE_A = 0;
	localparam int unsigned SRC_EXT_LINE_B = 1;
	localparam int unsigned SRC_EXT_LINE_C = 2;
	localparam int unsigned SRC_TIMER_ZERO_LOW = 3;
	localparam int unsigned SRC_EXT_LINE_E = 4;
	localparam int unsigned SRC_EXT_LINE_D = 5;
	localparam int unsigned SRC_BASE_TIMER = 6;
	localparam int unsigned SRC_TIMER_ZERO_HIGH = 7;
	localparam int unsigned SRC_TIMER_ONE_LOW = 8;
	localparam int unsigned SRC_TIMER_ONE_HIGH = 9;
	localparam int unsigned SRC_SERIAL_ZERO = 10;
	localparam int unsigned SRC_ASYNC_RECEIVE = 11;
	localparam int unsigned SRC_SERIAL_ONE = 12;
	localparam int unsigned SRC_ASYNC_TRANSMIT = 13;
	localparam int unsigned SRC_CONVERTER = 14;
	localparam int unsigned SRC_TIMER_SIX = 15;
	localparam int unsigned SRC_TIMER_SEVEN = 16;
	localparam int unsigned SRC_EXTRA_PULSE = 17;
	localparam int unsigned SRC_PORT_ZERO = 18;

	typedef enum logic [1:0] {
		LEVEL_NONE = 2'h0,
		LEVEL_LOW = 2'h1,
		LEVEL_HIGH = 2'h2,
		LEVEL_HIGHEST = 2'h3
	} level_type;

	typedef enum logic [3:0] {
		MODE_RUN = 4'b0001,
		MODE_HALT = 4'b0010,
		MODE_HOLD = 4'b0100,
		MODE_CRYSTAL_HOLD = 4'b1000
	} mode_type;

	localparam logic [1:0] REQ_NONE = 2'h0;
	localparam logic [1:0] REQ_HALT = 2'h1;
	localparam logic [1:0] REQ_HOLD = 2'h2;
	localparam logic [1:0] REQ_CRYSTAL_HOLD = 2'h3;

	// source number to vector index
	function automatic logic [3:0] src_vector(input int unsigned src);
		case (src)
			SRC_EXT_LINE_A: src_vector = 4'h0;
			SRC_EXT_LINE_B: src_vector = 4'h1;
			SRC_EXT_LINE_C, SRC_TIMER_ZERO_LOW, SRC_EXT_LINE_E: src_vector = 4'h2;
			SRC_EXT_LINE_D, SRC_BASE_TIMER: src_vector = 4'h3;
			SRC_TIMER_ZERO_HIGH: src_vector = 4'h4;
			SRC_TIMER_ONE_LOW, SRC_TIMER_ONE_HIGH: src_vector = 4'h5;
			SRC_SERIAL_ZERO, SRC_ASYNC_RECEIVE: src_vector = 4'h6;
			SRC_SERIAL_ONE, SRC_ASYNC_TRANSMIT: src_vector = 4'h7;
			SRC_CONVERTER, SRC_TIMER_SIX, SRC_TIMER_SEVEN,
			SRC_EXTRA_PULSE: src_vector = 4'h8;
			default: src_vector = 4'h9;
		endcase
	endfunction: src_vector
endpackage: pic_pkg

// File: core/vector_arbiter.sv
`timescale 1ns/10ps
module vector_arbiter (
	input wire logic [pic_pkg::NUM_VECTORS-1:0] pending,
	input wire logic [2*pic_pkg::NUM_VECTORS-1:0] level,
	output logic win_valid,
	output logic [3:0] win_vector,
	output logic [1:0] win_level
);
	import pic_pkg::*;

	// scan downward with >= so that the smaller vector wins a tie
	always_comb begin
		win_valid = 1'b0;
		win_vector = 4'h0;
		win_level = LEVEL_NONE;
		for (int i = NUM_VECTORS - 1; i >= 0; i--) begin
			if (pending[i] && level[2*i +: 2] >= win_level) begin
				win_valid = 1'b1;
				win_vector = i[3:0];
				win_level = level[2*i +: 2];
			end
		end
	end
endmodule: vector_arbiter

// File: core/standby_control.sv
`timescale 1ns/10ps
module standby_control (
	input wire logic clk,
	input wire logic rst,
	input wire logic enter_req,
	input wire logic [1:0] enter_mode,
	input wire logic reset_pin_n,
	input wire logic low_voltage_detect_reset,
	input wire logic watchdog_reset,
	input wire logic any_interrupt,
	input wire logic hold_wake,
	input wire logic base_timer_event,
	input wire logic crystal_sel,
	input wire logic crystal_on,
	output logic [3:0] mode,
	output logic cpu_stop,
	output logic periph_stop,
	output logic base_timer_stop,
	output logic osc_stop,
	output logic crystal_stop
);
	import pic_pkg::*;

	typedef struct packed {
		mode_type mode;
		logic cpu_stop;
		logic periph_stop;
		logic base_timer_stop;
		logic osc_stop;
		logic crystal_stop;
	} standby_type;

	standby_type cur;
	standby_type next_cur;
	logic system_reset;
	logic bt_wake;

	assign system_reset = !reset_pin_n || low_voltage_detect_reset ||
		watchdog_reset;
	assign bt_wake = base_timer_event && crystal_sel;

	always_comb begin
		next_cur = cur;
		case (cur.mode)
			MODE_RUN: begin
				if (enter_req && enter_mode == REQ_HALT)
					next_cur.mode = MODE_HALT;
				else if (enter_req && enter_mode == REQ_HOLD)
					next_cur.mode = MODE_HOLD;
				else if (enter_req && enter_mode == REQ_CRYSTAL_HOLD)
					next_cur.mode = MODE_CRYSTAL_HOLD;
			end
			MODE_HALT: begin
				if (system_reset || any_interrupt)
					next_cur.mode = MODE_RUN;
			end
			MODE_HOLD: begin
				if (system_reset || hold_wake)
					next_cur.mode = MODE_RUN;
			end
			MODE_CRYSTAL_HOLD: begin
				if (system_reset || hold_wake || bt_wake)
					next_cur.mode = MODE_RUN;
			end
			default: next_cur.mode = MODE_RUN;
		endcase
		// halt leaves the oscillators and peripherals alone
		next_cur.cpu_stop = next_cur.mode != MODE_RUN;
		next_cur.periph_stop = next_cur.mode == MODE_HOLD ||
			next_cur.mode == MODE_CRYSTAL_HOLD;
		next_cur.base_timer_stop = next_cur.mode == MODE_HOLD;
		next_cur.osc_stop = next_cur.periph_stop;
		// crystal hold freezes the crystal as it stood on entry
		if (next_cur.mode == MODE_HOLD)
			next_cur.crystal_stop = 1'b1;
		// the entry edge still follows crystal_on, so a control write that
		// starts the crystal together with the request is not lost
		else if (cur.mode != MODE_CRYSTAL_HOLD)
			next_cur.crystal_stop = !crystal_on;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cur <= '{MODE_RUN, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
		end else begin
			cur <= next_cur;
		end
	end

	assign mode = cur.mode;
	assign cpu_stop = cur.cpu_stop;
	assign periph_stop = cur.periph_stop;
	assign base_timer_stop = cur.base_timer_stop;
	assign osc_stop = cur.osc_stop;
	assign crystal_stop = cur.crystal_stop;

	property p_halt_keeps_running;
		@(posedge clk) disable iff (rst)
		cur.mode == MODE_HALT |-> cpu_stop && !periph_stop && !osc_stop;
	endproperty
	a_halt_keeps_running: assert property (p_halt_keeps_running)
		else $error("halt stopped peripherals or oscillators");

	property p_halt_exit;
		@(posedge clk) disable iff (rst)
		cur.mode == MODE_HALT && (any_interrupt || system_reset)
			|=> cur.mode == MODE_RUN && !cpu_stop;
	endproperty
	a_halt_exit: assert property (p_halt_exit)
		else $error("halt not left on interrupt or reset");

	property p_hold_stops_all;
		@(posedge clk) disable iff (rst)
		cur.mode == MODE_HOLD |-> periph_stop && osc_stop && crystal_stop &&
			base_timer_stop;
	endproperty
	a_hold_stops_all: assert property (p_hold_stops_all)
		else $error("hold left something running");

	property p_hold_exit;
		@(posedge clk) disable iff (rst)
		cur.mode == MODE_HOLD && (hold_wake || system_reset)
			|=> cur.mode == MODE_RUN;
	endproperty
	a_hold_exit: assert property (p_hold_exit)
		else $error("hold not left on wake source");

	property p_hold_stays;
		@(posedge clk) disable iff (rst)
		cur.mode == MODE_HOLD && !hold_wake && !system_reset
			|=> cur.mode == MODE_HOLD;
	endproperty
	a_hold_stays: assert property (p_hold_stays)
		else $error("hold left without a wake source");

	property p_crystal_hold_retains;
		@(posedge clk) disable iff (rst)
		cur.mode == MODE_CRYSTAL_HOLD ##1 cur.mode == MODE_CRYSTAL_HOLD
			|-> $stable(crystal_stop) && !base_timer_stop && periph_stop;
	endproperty
	a_crystal_hold_retains: assert property (p_crystal_hold_retains)
		else $error("crystal hold changed crystal or base timer");

	property p_base_timer_wake;
		@(posedge clk) disable iff (rst)
		cur.mode == MODE_CRYSTAL_HOLD && base_timer_event && !hold_wake &&
			!system_reset |=> cur.mode == ($past(crystal_sel) ? MODE_RUN :
			MODE_CRYSTAL_HOLD);
	endproperty
	a_base_timer_wake: assert property (p_base_timer_wake)
		else $error("base timer wake mishandled");
endmodule: standby_control

// File: testbench/cpu_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// cpu side: takes an offered vector after a chosen wait
// ----------------------------------------------------------------
module cpu_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic irq_request,
	input wire logic ack_en,
	input wire logic [1:0] ack_delay,
	output logic cpu_ack,
	output logic cpu_return
);
	logic [1:0] wait_count;

	// ack only while the offer stands, never twice for one offer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cpu_ack <= 1'b0;
			wait_count <= 2'h0;
		end else if (cpu_ack || !irq_request || !ack_en) begin
			cpu_ack <= 1'b0;
			wait_count <= 2'h0;
		end else if (wait_count >= ack_delay) begin
			cpu_ack <= 1'b1;
		end else begin
			wait_count <= wait_count + 2'h1;
		end
	end

	task automatic give_return();
		@(posedge clk);
		cpu_return <= 1'b1;
		@(posedge clk);
		cpu_return <= 1'b0;
	endtask: give_return

	initial cpu_return = 1'b0;
endmodule: cpu_model

// File: testbench/priority_interrupt_standby_wake_tb_top.sv
`timescale 1ns/10ps
`define CHK(got, exp) begin \
	checked++; \
	if ((got) !== (exp)) begin \
		fail_count++; \
		$display("ERROR t=%0t got=%h exp=%h", $time, got, exp); \
	end \
end
module priority_interrupt_standby_wake_tb_top;
	import pic_pkg::*;
	logic clk, rst, write_strobe, read_strobe, cpu_ack, cpu_return, ack_en;
	logic irq_request, int_out, reset_pin_n, low_voltage_detect_reset;
	logic watchdog_reset, cpu_stop, periph_stop, base_timer_stop;
	logic osc_stop, crystal_stop;
	logic [1:0] ack_delay, irq_level;
	logic [7:0] addr, vector_addr;
	logic [31:0] wdata, rdata, r;
	logic [18:0] src_event, ev;
	logic [3:0] standby_mode;
	logic [9:0] pri;
	logic [13:0] cs;
	logic [8:0] sb;
	int act;
	int fail_count = 0;
	int checked = 0;
	int seed = 66034;
	int vmap [19] = '{0, 1, 2, 2, 2, 3, 3, 4, 5, 5, 6, 6, 7, 7, 8, 8, 8, 8, 9};
	// {control byte, wake action, wakes}; 19 watchdog, 20 low voltage, 21 pin
	logic [13:0] sb_case [13] = '{{8'h10, 5'd18, 1'b1}, {8'h10, 5'd19, 1'b1},
		{8'h20, 5'd5, 1'b0}, {8'h20, 5'd4, 1'b1}, {8'h20, 5'd0, 1'b0},
		{8'h21, 5'd0, 1'b1}, {8'h22, 5'd1, 1'b1}, {8'h38, 5'd6, 1'b0},
		{8'h3c, 5'd6, 1'b1}, {8'h30, 5'd21, 1'b1}, {8'h20, 5'd20, 1'b1},
		{8'h20, 5'd18, 1'b1}, {8'h20, 5'd8, 1'b0}};

	priority_interrupt_standby_wake u_dut (.clk(clk), .rst(rst), .addr(addr),
		.wdata(wdata), .write_strobe(write_strobe), .read_strobe(read_strobe),
		.rdata(rdata), .src_event(src_event), .cpu_ack(cpu_ack),
		.cpu_return(cpu_return), .irq_request(irq_request),
		.vector_addr(vector_addr), .irq_level(irq_level), .int_out(int_out),
		.reset_pin_n(reset_pin_n), .watchdog_reset(watchdog_reset),
		.low_voltage_detect_reset(low_voltage_detect_reset),
		.standby_mode(standby_mode), .cpu_stop(cpu_stop),
		.periph_stop(periph_stop), .base_timer_stop(base_timer_stop),
		.osc_stop(osc_stop), .crystal_stop(crystal_stop));

	cpu_model u_cpu (.clk(clk), .rst(rst), .irq_request(irq_request),
		.ack_en(ack_en), .ack_delay(ack_delay), .cpu_ack(cpu_ack),
		.cpu_return(cpu_return));

	// ----------------------------------------------------------------
	// expectations
	// ----------------------------------------------------------------
	function automatic logic [9:0] exp_win(input logic [18:0] e,
		input logic [9:0] p);
		logic [1:0] best;
		logic [1:0] lv;
		logic [7:0] va;
		best = 2'h0;
		va = 8'h03;
		// sources run in rising vector order, so a tie keeps the first
		for (int s = 0; s < 19; s++) begin
			lv = !p[vmap[s]] ? 2'h1 : (vmap[s] < 2 ? 2'h3 : 2'h2);
			if (e[s] && lv > best) begin
				best = lv;
				va = 8'h03 + 8'(vmap[s] * 8);
			end
		end
		return {va, best};
	endfunction: exp_win

	function automatic logic [8:0] exp_standby(input logic [1:0] m,
		input logic xon);
		case (m)
			2'h0: return {4'b0001, 4'b0000, !xon};
			2'h1: return {4'b0010, 4'b1000, !xon};
			2'h2: return {4'b0100, 4'b1111, 1'b1};
			default: return {4'b1000, 4'b1101, !xon};
		endcase
	endfunction: exp_standby

	// ----------------------------------------------------------------
	// drivers
	// ----------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		write_strobe <= 1'b1;
		@(posedge clk);
		write_strobe <= 1'b0;
	endtask: wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		read_strobe <= 1'b1;
		@(posedge clk);
		read_strobe <= 1'b0;
		#1;
		`CHK(rdata, exp)
	endtask: rd

	task automatic pulse(input logic [18:0] e, input logic [2:0] k);
		@(posedge clk);
		r = $random(seed);
		ack_delay <= r[1:0];
		src_event <= e;
		{reset_pin_n, low_voltage_detect_reset, watchdog_reset} <= k ^ 3'h4;
		@(posedge clk);
		src_event <= '0;
		{reset_pin_n, low_voltage_detect_reset, watchdog_reset} <= 3'h4;
	endtask: pulse

	task automatic wait_irq(input logic lvl);
		#1;
		for (int n = 0; n < 8 && irq_request !== lvl; n++) begin
			@(posedge clk);
			#1;
		end
	endtask: wait_irq

	task automatic report_and_stop();
		if (fail_count == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask: report_and_stop

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	initial begin
		#200_000;
		fail_count++;
		report_and_stop();
	end

	initial begin
		rst = 1'b1;
		{write_strobe, read_strobe, low_voltage_detect_reset} = '0;
		{watchdog_reset, ack_en, ack_delay, addr, wdata, src_event} = '0;
		reset_pin_n = 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		`CHK({vector_addr, standby_mode, crystal_stop}, 13'h063)
		rd(OFFSET_MASK, 32'h0);
		rd(OFFSET_STATE, 32'h0000_3004);
		rd(8'h40, 32'h0);
		wr(8'h44, 32'hffff_ffff);
		wr(OFFSET_CONTROL, 32'h0000_000d);
		rd(OFFSET_CONTROL, 32'h0000_000d);
		// masked source: flag set, nothing raised
		pulse(19'h1 << 10, 3'h0);
		rd(OFFSET_STATUS, 32'h0000_0400);
		`CHK({int_out, irq_request}, 2'b00)
		wr(OFFSET_PRIORITY, 32'h0);
		wr(OFFSET_MASK, 32'h0007_ffff);
		repeat (3) @(posedge clk);
		#1;
		`CHK({int_out, irq_request, vector_addr}, 10'h333)
		wr(OFFSET_STATUS, 32'h0007_ffff);
		for (int i = 0; i < 40; i++) begin
			r = $random(seed);
			pri = r[9:0];
			r = $random(seed);
			ev = (i == 0) ? '1 : r[18:0];
			if (ev == '0) ev = 19'h4_0000;
			wr(OFFSET_PRIORITY, {22'h0, pri});
			pulse(ev, 3'h0);
			wait_irq(1'b1);
			`CHK({irq_request, vector_addr, irq_level}, {1'b1, exp_win(ev, pri)})
			rd(OFFSET_STATUS, {13'h0, ev});
			wr(OFFSET_STATUS, {13'h0, ev});
			repeat (3) @(posedge clk);
			#1;
			`CHK({int_out, irq_request}, 2'b00)
		end
		foreach (sb_case[k]) begin
			cs = sb_case[k];
			wr(OFFSET_CONTROL, {24'h0, cs[13:6]});
			repeat (2) @(posedge clk);
			#1;
			sb = exp_standby(cs[11:10], cs[9]);
			`CHK({standby_mode, cpu_stop, periph_stop, base_timer_stop, osc_stop, crystal_stop}, sb)
			// flip the crystal while in crystal hold: its stop must not follow
			if (cs[11:10] == 2'h3) begin
				wr(OFFSET_CONTROL, {24'h0, cs[13:6] ^ 8'h38});
				cs[9] = !cs[9];
				repeat (2) @(posedge clk);
				#1;
				`CHK({standby_mode, cpu_stop, periph_stop, base_timer_stop, osc_stop, crystal_stop}, sb)
			end
			act = int'(cs[5:1]);
			pulse(act < 19 ? 19'h1 << act : 19'h0, act < 19 ? 3'h0 : 3'h1 << (act - 19));
			repeat (4) @(posedge clk);
			#1;
			`CHK(standby_mode, cs[0] ? 4'b0001 : sb[8:5])
			if (!cs[0]) pulse(19'h0, 3'h1);
			repeat (3) @(posedge clk);
			#1;
			`CHK({standby_mode, cpu_stop, periph_stop, base_timer_stop, osc_stop, crystal_stop}, exp_standby(2'h0, cs[9]))
			wr(OFFSET_STATUS, 32'h0007_ffff);
		end
		// nested service: L, then H, then X, popped in reverse
		ack_en <= 1'b1;
		wr(OFFSET_PRIORITY, 32'h0000_0011);
		pulse(19'h1 << 18, 3'h0);
		wait_irq(1'b1);
		`CHK({irq_request, vector_addr, irq_level}, 11'h52d)
		wait_irq(1'b0);
		pulse(19'h1 << 2, 3'h0);
		repeat (4) @(posedge clk);
		#1;
		`CHK(irq_request, 1'b0)
		pulse(19'h1 << 7, 3'h0);
		wait_irq(1'b1);
		`CHK({irq_request, vector_addr, irq_level}, 11'h48e)
		wait_irq(1'b0);
		pulse(19'h1, 3'h0);
		wait_irq(1'b1);
		`CHK({irq_request, vector_addr, irq_level}, 11'h40f)
		wait_irq(1'b0);
		wr(OFFSET_STATUS, 32'h0000_0081);
		u_cpu.give_return();
		u_cpu.give_return();
		repeat (4) @(posedge clk);
		#1;
		`CHK(irq_request, 1'b0)
		u_cpu.give_return();
		wait_irq(1'b1);
		`CHK({irq_request, vector_addr, irq_level}, 11'h44d)
		report_and_stop();
	end
endmodule: priority_interrupt_standby_wake_tb_top
